// ===== verilog/timing_regs_pkg.sv
package timing_regs_pkg;
  // ***********************************************
  // register indices, byte address is four times
  // ***********************************************
  localparam logic [7:0] IDX_BANDWIDTH = 8'h0D;
  localparam logic [7:0] IDX_TOTAL_UP = 8'h0E;
  localparam logic [7:0] IDX_TOTAL_LO = 8'h0F;
  localparam logic [7:0] IDX_PHASE = 8'h10;
  localparam logic [7:0] IDX_PRE = 8'h11;
  localparam logic [7:0] IDX_POST = 8'h12;
  localparam logic [7:0] IDX_MISC = 8'h13;
  localparam logic [7:0] IDX_START_UP = 8'h14;
  localparam logic [7:0] IDX_START_LO = 8'h15;
  localparam logic [7:0] IDX_WIDTH = 8'h16;
  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic [7:0] RST_BANDWIDTH = 8'h0E;
  localparam logic [7:0] RST_TOTAL_UP = 8'h03;
  localparam logic [7:0] RST_TOTAL_LO = 8'h20;
  localparam logic [7:0] RST_PRE = 8'h08;
  localparam logic [7:0] RST_WIDTH = 8'h10;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // ***********************************************
  // field positions and codes
  // ***********************************************
  localparam int MISC_EDGE1 = 0;
  localparam int MISC_EDGE2 = 1;
  localparam int MISC_PIN_DIS = 3;
  localparam int MISC_HALF = 6;
  localparam int MISC_XOFF = 7;
  localparam logic [1:0] PIN_INVERT = 2'h0;
  localparam logic [1:0] PIN_CLAMP = 2'h1;
  localparam logic [1:0] PIN_HOLD = 2'h2;
  localparam logic [1:0] PIN_EXTERNAL_PIXEL_CLOCK = 2'h3;
  localparam logic [7:0] WIDTH_MIN = 8'h02;
  localparam logic [7:0] RESERVED_MISC = 8'hFB;
  localparam logic [7:0] MASK_START_UP = 8'h1F;
  localparam logic [7:0] MASK_TOTAL_UP = 8'h3F;
  localparam logic [31:0] RDATA_BAD = 32'h0000_0000;
  // ***********************************************
  // pending converter update delay
  // ***********************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int UPDATE_MS = 100;
  localparam int UPDATE_CYC = CLK_HZ / 1000 * UPDATE_MS;
  // ***********************************************
  // clamp sequencer states
  // ***********************************************
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_COUNT = 3'b010,
    ST_CLAMP = 3'b100
  } clamp_state_t;
endpackage

// ===== verilog/pll_clamp_timing_regs.sv
// Summary of operation
// - bandwidth bits 3:1 pick filter corner
// - bandwidth bits 7:4 pick peaking, zero off
// - line total joins upper 5:0, lower 7:0
// - line total updates on lower write only
// - six-bit phase steps sample point
// - hold loop given lines before frame sync
// - hold loop given lines after frame sync
// - counts ignored for external holdover
// - misc bit 0 picks first sync edge
// - misc bit 1 picks second sync edge
// - misc bit 3 forces pin value low
// - misc bits 5:4 choose pin role
// - clamp pulse restores, starts black, loads offsets
// - internal clamp mode pulses automatically
// - external clamp loads offsets on leading edge
// - no clamp: offsets load within 100ms
// - misc bit 6 halves crystal clock output
// - misc bit 7 holds crystal output low
// - clamp starts at 13-bit count after sync
// - clamp width in pixels, black unaffected
// - widths below two give no pulse
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
module pll_clamp_timing_regs
#(
  parameter int UPDATE_CYCLES = timing_regs_pkg::UPDATE_CYC // pending load delay
)
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic first_line_sync_input_i, // line sync 1 pin
  input wire logic second_line_sync_input_i, // line sync 2 pin
  input wire logic sync_select_i, // 0 uses sync 1, 1 uses sync 2
  input wire logic frame_sync_i, // frame sync pin
  input wire logic multipurpose_invert_pin_i,
  input wire logic offsets_pending_i, // gain or offset written, waiting
  output logic [2:0] frontend_filter_corner_o,
  output logic [3:0] peaking_o,
  output logic [13:0] line_total_o,
  output logic [5:0] sample_phase_o,
  output logic lock_edge_leading_o, // lock edge for the active sync
  output logic loop_hold_o, // clock loop holdover
  output logic clock_invert_o,
  output logic external_pixel_clock_sel_o,
  output logic crystal_half_o,
  output logic crystal_clock_enable_o,
  output logic restore_pulse_o, // dc restore clamp
  output logic black_level_start_o, // one-cycle start of black level
  output logic offset_load_o // one-cycle converter load
);
  import timing_regs_pkg::*;
  // ***********************************************
  // register storage
  // ***********************************************
  logic [7:0] bw_reg; // frontend_bandwidth
  logic [7:0] tot_up_reg; // line_total_upper
  logic [7:0] tot_lo_reg; // line_total_lower
  logic [7:0] phase_reg; // sample_phase
  logic [7:0] pre_reg; // holdover_before_frame
  logic [7:0] post_reg; // holdover_after_frame
  logic [7:0] misc_reg; // loop_misc_control
  logic [7:0] st_up_reg; // restore_start_upper
  logic [7:0] st_lo_reg; // restore_start_lower
  logic [7:0] wid_reg; // restore_clamp_width
  logic [13:0] total_reg; // value in use by the loop
  logic ready_reg;
  logic [31:0] rdata_reg;
  logic err_reg;

  // ***********************************************
  // bus decode
  // ***********************************************
  wire logic [9:0] word_idx = paddr_i[11:2]; // word index
  wire logic access = psel_i && penable_i && !ready_reg;
  wire logic wr_en = access && pwrite_i;
  wire logic hit = (paddr_i[1:0] == 2'h0) && (word_idx >= {2'h0, IDX_BANDWIDTH})
    && (word_idx <= {2'h0, IDX_WIDTH});
  wire logic [7:0] sel = word_idx[7:0];
  wire logic wr_bw = wr_en && hit && sel == IDX_BANDWIDTH;
  wire logic wr_tu = wr_en && hit && sel == IDX_TOTAL_UP;
  wire logic wr_tl = wr_en && hit && sel == IDX_TOTAL_LO;
  wire logic wr_ph = wr_en && hit && sel == IDX_PHASE;
  wire logic wr_pre = wr_en && hit && sel == IDX_PRE;
  wire logic wr_post = wr_en && hit && sel == IDX_POST;
  wire logic wr_misc = wr_en && hit && sel == IDX_MISC;
  wire logic wr_su = wr_en && hit && sel == IDX_START_UP;
  wire logic wr_sl = wr_en && hit && sel == IDX_START_LO;
  wire logic wr_wid = wr_en && hit && sel == IDX_WIDTH;
  wire logic [7:0] wbyte = pwdata_i[7:0];
  // read selection
  wire logic [7:0] rbyte =
    (sel == IDX_BANDWIDTH) ? bw_reg :
    (sel == IDX_TOTAL_UP) ? tot_up_reg :
    (sel == IDX_TOTAL_LO) ? tot_lo_reg :
    (sel == IDX_PHASE) ? phase_reg :
    (sel == IDX_PRE) ? pre_reg :
    (sel == IDX_POST) ? post_reg :
    (sel == IDX_MISC) ? misc_reg :
    (sel == IDX_START_UP) ? st_up_reg :
    (sel == IDX_START_LO) ? st_lo_reg : wid_reg;
  wire logic [31:0] rdata_next = hit ? {24'h000000, rbyte} : RDATA_BAD;

  // ***********************************************
  // apb slave, one wait state
  // ***********************************************
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ready_reg <= 1'b0;
      rdata_reg <= RDATA_BAD;
      err_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= access; // answer next cycle
      rdata_reg <= access ? rdata_next : rdata_reg;
      err_reg <= access && !hit;
    end
  end
  // register writes
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      bw_reg <= RST_BANDWIDTH;
      tot_up_reg <= RST_TOTAL_UP;
      tot_lo_reg <= RST_TOTAL_LO;
      phase_reg <= RST_ZERO;
      pre_reg <= RST_PRE;
      post_reg <= RST_ZERO;
      misc_reg <= RST_ZERO;
      st_up_reg <= RST_ZERO;
      st_lo_reg <= RST_ZERO;
      wid_reg <= RST_WIDTH;
      total_reg <= {RST_TOTAL_UP[5:0], RST_TOTAL_LO};
    end
    else
    begin
      if (wr_bw) bw_reg <= wbyte;
      if (wr_tu) tot_up_reg <= wbyte & MASK_TOTAL_UP;
      if (wr_tl) tot_lo_reg <= wbyte;
      if (wr_tl) total_reg <= {tot_up_reg[5:0], wbyte};
      if (wr_ph) phase_reg <= wbyte & MASK_TOTAL_UP;
      if (wr_pre) pre_reg <= wbyte;
      if (wr_post) post_reg <= wbyte;
      if (wr_misc) misc_reg <= wbyte & RESERVED_MISC;
      if (wr_su) st_up_reg <= wbyte & MASK_START_UP;
      if (wr_sl) st_lo_reg <= wbyte;
      if (wr_wid) wid_reg <= wbyte;
    end
  end

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic [3:0] prev_reg;
  wire logic [3:0] pins = {multipurpose_invert_pin_i, frame_sync_i,
    second_line_sync_input_i, first_line_sync_input_i};
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
      prev_reg <= 4'h0;
    end
    else
    begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // ***********************************************
  // pin role and edge selection
  // ***********************************************
  wire logic [1:0] role = misc_reg[5:4];
  wire logic pin_val = sync_reg[3] && !misc_reg[MISC_PIN_DIS];
  wire logic pin_rise = pin_val && !(prev_reg[3] && !misc_reg[MISC_PIN_DIS]);
  wire logic line_now = sync_select_i ? sync_reg[1] : sync_reg[0];
  wire logic line_was = sync_select_i ? prev_reg[1] : prev_reg[0];
  wire logic line_fall = line_was && !line_now; // trailing edge
  wire logic line_rise = line_now && !line_was;
  wire logic edge_lead = sync_select_i ? misc_reg[MISC_EDGE2]
    : misc_reg[MISC_EDGE1];
  wire logic frame_rise = sync_reg[2] && !prev_reg[2];
  wire logic frame_fall = prev_reg[2] && !sync_reg[2];
  wire logic ext_clamp = role == PIN_CLAMP;
  wire logic ext_hold = role == PIN_HOLD;

  // ***********************************************
  // internal holdover: lines before and after frame
  // ***********************************************
  logic [7:0] line_cnt_reg; // lines since frame end
  logic [7:0] frame_len_reg; // lines from frame end to next start
  logic post_act_reg;
  logic int_hold_reg;
  // predict the next frame start from the last frame spacing
  wire logic [8:0] pre_reach = {1'b0, line_cnt_reg} + {1'b0, pre_reg}; // lines ahead
  wire logic pre_zone = (pre_reach > {1'b0, frame_len_reg}) && (pre_reg != 8'h00);
  wire logic post_zone = post_act_reg && (line_cnt_reg <= post_reg) && (post_reg != 8'h00);
  wire logic hold_next = ext_hold ? pin_val
    : (sync_reg[2] || pre_zone || post_zone);
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      line_cnt_reg <= 8'h00;
      frame_len_reg <= 8'h00;
      post_act_reg <= 1'b0;
      int_hold_reg <= 1'b0;
    end
    else
    begin
      if (frame_fall)
        line_cnt_reg <= 8'h00; // restart line count at frame end
      else if (line_fall && line_cnt_reg != 8'hFF)
        line_cnt_reg <= line_cnt_reg + 8'h01;
      if (frame_rise)
        frame_len_reg <= line_cnt_reg;
      post_act_reg <= frame_fall || (post_act_reg && !frame_rise); // after-frame window
      int_hold_reg <= hold_next;
    end
  end

  // ***********************************************
  // clamp sequencer
  // ***********************************************
  clamp_state_t state_reg;
  clamp_state_t state_next;
  logic [12:0] pix_reg;
  logic [12:0] pix_next;
  logic [23:0] wait_reg; // pending load timer
  wire logic [12:0] start_cnt = {st_up_reg[4:0], st_lo_reg};
  wire logic int_mode = !ext_clamp;
  wire logic at_start = state_reg == ST_COUNT && pix_reg == start_cnt;
  wire logic wide_ok = wid_reg >= WIDTH_MIN;
  wire logic at_end = state_reg == ST_CLAMP // last pixel, or width cut below minimum
    && (!wide_ok || pix_reg + 13'h0001 >= {5'h00, wid_reg});
  wire logic timer_done = wait_reg == UPDATE_CYCLES[23:0];
  // clamp events: internal start point, or external leading edge
  wire logic int_clamp = int_mode && at_start;
  wire logic load_next = (ext_clamp ? pin_rise : int_clamp)
    || (offsets_pending_i && timer_done);
  always_comb
  begin
    state_next = state_reg;
    pix_next = pix_reg + 13'h0001;
    case (state_reg)
      ST_WAIT:
      begin
        pix_next = 13'h0000;
        if (line_fall && int_mode) state_next = ST_COUNT;
      end
      ST_COUNT:
      begin
        if (at_start)
        begin
          pix_next = 13'h0000;
          state_next = wide_ok ? ST_CLAMP : ST_WAIT;
        end
      end
      ST_CLAMP:
        if (at_end) state_next = ST_WAIT;
      default:
      begin
        state_next = ST_WAIT;
        pix_next = 13'h0000;
      end
    endcase
  end

  // ***********************************************
  // output flops
  // ***********************************************
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_reg <= ST_WAIT;
      pix_reg <= 13'h0000;
      wait_reg <= 24'h000000;
      restore_pulse_o <= 1'b0;
      black_level_start_o <= 1'b0;
      offset_load_o <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pix_reg <= pix_next;
      wait_reg <= (!offsets_pending_i || timer_done) ? 24'h000000 : wait_reg + 24'h000001;
      restore_pulse_o <= (state_next == ST_CLAMP) || (ext_clamp && pin_val);
      black_level_start_o <= ext_clamp ? pin_rise : int_clamp;
      offset_load_o <= load_next;
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      frontend_filter_corner_o <= RST_BANDWIDTH[3:1];
      peaking_o <= RST_BANDWIDTH[7:4];
      line_total_o <= {RST_TOTAL_UP[5:0], RST_TOTAL_LO};
      sample_phase_o <= 6'h00;
      lock_edge_leading_o <= 1'b0;
      loop_hold_o <= 1'b0;
      clock_invert_o <= 1'b0;
      external_pixel_clock_sel_o <= 1'b0;
      crystal_half_o <= 1'b0;
      crystal_clock_enable_o <= 1'b1; // enabled, as the misc reset value says
    end
    else
    begin
      frontend_filter_corner_o <= bw_reg[3:1];
      peaking_o <= bw_reg[7:4];
      line_total_o <= total_reg;
      sample_phase_o <= phase_reg[5:0];
      lock_edge_leading_o <= edge_lead;
      loop_hold_o <= int_hold_reg;
      clock_invert_o <= (role == PIN_INVERT) && pin_val;
      external_pixel_clock_sel_o <= role == PIN_EXTERNAL_PIXEL_CLOCK;
      crystal_half_o <= misc_reg[MISC_HALF];
      crystal_clock_enable_o <= !misc_reg[MISC_XOFF];
    end
  end
  assign prdata_o = rdata_reg;
  assign pready_o = ready_reg;
  assign pslverr_o = err_reg;

  // ***********************************************
  // checks
  // ***********************************************
  total_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_tu && !wr_tl |=> $stable(total_reg)) else $error("upper write moved total");
  total_load_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_tl |=> ##1 line_total_o == {tot_up_reg[5:0], tot_lo_reg})
    else $error("line total not joined");
  narrow_clamp_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    wid_reg < WIDTH_MIN && !ext_clamp |-> state_next != ST_CLAMP)
    else $error("clamp for narrow width");
  ext_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    ext_hold && $stable(ext_hold) |=> int_hold_reg == $past(pin_val))
    else $error("external holdover not followed");
  pin_force_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    misc_reg[MISC_PIN_DIS] |=> !clock_invert_o) else $error("pin not forced low");
  xtal_off_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    misc_reg[MISC_XOFF] |=> !crystal_clock_enable_o) else $error("crystal not off");
  ext_load_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    ext_clamp && !offsets_pending_i && !pin_rise |=> !offset_load_o)
    else $error("offset load off edge");
  clamp_start_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    int_clamp |=> black_level_start_o && offset_load_o) else $error("clamp start lost");
endmodule

// ===== tb/sync_source.sv
`timescale 1ns/10ps
// ****
// graphics source: line and frame sync
// ****
module sync_source
#(
  parameter int LINE_CYC = 320, // cycles per line
  parameter int SYNC_W = 8, // line sync width
  parameter int FRAME_LINES = 10, // lines per frame
  parameter int FRAME_W = 1 // frame sync width in lines
)
(
  input wire logic mclk_i,
  input wire logic run_i, // source active
  output logic line_sync_o,
  output logic frame_sync_o
);
  int pix_reg = 0; // pixel in line
  int line_reg = 0; // line in frame
  // line and frame counters
  always @(posedge mclk_i)
  begin
    if (!run_i)
    begin
      pix_reg <= 0;
      line_reg <= 0;
    end
    else
    begin
      pix_reg <= (pix_reg == LINE_CYC - 1) ? 0 : pix_reg + 1;
      if (pix_reg == LINE_CYC - 1)
        line_reg <= (line_reg == FRAME_LINES - 1) ? 0 : line_reg + 1;
    end
  end
  // pulses high, lines idle low when stopped
  assign line_sync_o = run_i && pix_reg < SYNC_W;
  assign frame_sync_o = run_i && line_reg < FRAME_W;
endmodule

// ===== tb/pll_clamp_timing_regs_tb.sv
`timescale 1ns/10ps
// ****
// bench for the timing register bank
// ****
module pll_clamp_timing_regs_tb;
  import timing_regs_pkg::*;
  localparam int LINE = 320; // cycles per line
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic sel = 1'b0;
  logic pin = 1'b0;
  logic pend = 1'b0;
  logic run = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, line_s, frame_s, lead, hold, inv, pxs, half, xen;
  logic rest, blk, load;
  logic [2:0] corner;
  logic [3:0] peak;
  logic [13:0] total;
  logic [13:0] exp_total = 14'h0320; // loop total in use
  logic [5:0] phase;
  logic [7:0] v, up, lo, m;
  int failures = 0;
  int samples_checked = 0;
  int n, nr, nb, nl, d1, d2;
  logic [7:0] ridx [10] = '{IDX_BANDWIDTH, IDX_TOTAL_UP, IDX_TOTAL_LO, IDX_PHASE, IDX_PRE,
    IDX_POST, IDX_MISC, IDX_START_UP, IDX_START_LO, IDX_WIDTH};
  logic [7:0] rval [10] = '{RST_BANDWIDTH, RST_TOTAL_UP, RST_TOTAL_LO, RST_ZERO, RST_PRE,
    RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_WIDTH};
  logic [7:0] wtab [4] = '{8'h00, 8'h01, 8'h02, 8'h05}; // clamp widths

  always #50 mclk = ~mclk;

  pll_clamp_timing_regs #(.UPDATE_CYCLES(20)) dut (.mclk_i(mclk), .reset_i(rst),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .first_line_sync_input_i(line_s), .second_line_sync_input_i(line_s),
    .sync_select_i(sel), .frame_sync_i(frame_s), .multipurpose_invert_pin_i(pin),
    .offsets_pending_i(pend), .frontend_filter_corner_o(corner), .peaking_o(peak),
    .line_total_o(total), .sample_phase_o(phase), .lock_edge_leading_o(lead),
    .loop_hold_o(hold), .clock_invert_o(inv), .external_pixel_clock_sel_o(pxs),
    .crystal_half_o(half), .crystal_clock_enable_o(xen), .restore_pulse_o(rest),
    .black_level_start_o(blk), .offset_load_o(load));
  sync_source #(.LINE_CYC(LINE)) src (.mclk_i(mclk), .run_i(run), .line_sync_o(line_s),
    .frame_sync_o(frame_s));

  // ****
  // helpers
  // ****
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
  function automatic logic [13:0] total_of(input logic [7:0] u, input logic [7:0] l);
    return {u[5:0], l};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    pen <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk);
  endtask
  // counts restore cycles, black starts and loads
  task automatic window(input int k);
    nr = 0;
    nb = 0;
    nl = 0;
    repeat (k)
    begin
      @(posedge mclk);
      nr += int'(rest === 1'b1);
      nb += int'(blk === 1'b1);
      nl += int'(load === 1'b1);
    end
  endtask
  // cycles from line sync trailing edge to black start
  task automatic lag(output int d);
    d = 0;
    @(negedge line_s);
    while (blk !== 1'b1)
    begin
      @(posedge mclk);
      d++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial
  begin
    tick(60000);
    failures++;
    end_sim();
  end

  // ****
  // main sequence
  // ****
  initial
  begin
    void'($urandom(92621));
    tick(20);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (ridx[i])
    begin
      apb(1'b0, ba(ridx[i]), 8'h00);
      check("reset value", rd, {24'h0, rval[i]});
    end
    check("corner", corner, 32'h7);
    check("peaking", peak, 32'h0);
    check("total", total, 32'h320);
    // random programming of the loop registers
    for (int r = 0; r < 8; r++)
    begin
      v = 8'($urandom);
      up = 8'($urandom) | 8'h02;
      lo = 8'($urandom);
      apb(1'b1, ba(IDX_BANDWIDTH), v);
      apb(1'b1, ba(IDX_PHASE), lo);
      apb(1'b1, ba(IDX_TOTAL_UP), up);
      tick(2);
      check("total held", total, exp_total);
      apb(1'b1, ba(IDX_TOTAL_LO), lo);
      tick(2);
      exp_total = total_of(up, lo);
      check("total", total, exp_total);
      check("corner", corner, v[3:1]);
      check("peaking", peak, v[7:4]);
      check("phase", phase, lo[5:0]);
      apb(1'b0, ba(IDX_TOTAL_UP), 8'h00);
      check("upper readback", rd, up & MASK_TOTAL_UP);
    end
    // every lock edge, pin role and pin disable, random crystal choice
    for (int k = 0; k < 32; k++)
    begin
      m = {2'($urandom), k[4:3], k[2], 1'b0, k[1:0]};
      pin <= 1'($urandom);
      sel <= 1'($urandom);
      apb(1'b1, ba(IDX_MISC), m);
      tick(4);
      check("lock edge", lead, sel ? m[1] : m[0]);
      check("pixel clock select", pxs, m[5:4] == PIN_EXTERNAL_PIXEL_CLOCK);
      check("clock invert", inv, m[5:4] == PIN_INVERT && !m[3] && pin);
      check("crystal half", half, m[6]);
      check("crystal enable", xen, !m[7]);
    end
    // unaligned and unmapped accesses refused
    apb(1'b1, ba(IDX_BANDWIDTH) + 12'h001, 8'hFF);
    check("unaligned error", err, 1'b1);
    apb(1'b0, 12'hFFC, 8'h00);
    check("unmapped error", err, 1'b1);
    check("unmapped read", rd, RDATA_BAD);
    check("corner kept", corner, v[3:1]);
    // internal clamp, widths around the minimum
    pin <= 1'b0;
    run <= 1'b1;
    apb(1'b1, ba(IDX_MISC), 8'h00);
    foreach (wtab[j])
    begin
      apb(1'b1, ba(IDX_WIDTH), wtab[j]);
      tick(2 * LINE);
      window(3 * LINE);
      check("restore cycles", nr, (wtab[j] >= WIDTH_MIN) ? 3 * wtab[j] : 0);
      check("black starts", nb, 3);
      check("offset loads", nl, 3);
    end
    // start position joins upper and lower bytes
    apb(1'b1, ba(IDX_START_LO), 8'($urandom_range(40, 10)));
    lag(d1);
    lag(d1);
    apb(1'b1, ba(IDX_START_UP), 8'h01);
    lag(d2);
    lag(d2);
    check("start offset", d2 - d1, 256);
    apb(1'b1, ba(IDX_START_UP), 8'h00);
    // external clamp pin drives the loads
    apb(1'b1, ba(IDX_MISC), 8'h10);
    tick(4);
    nl = 0;
    for (int c = 0; c < 100; c++)
    begin
      pin <= (c % 30) < 4;
      @(posedge mclk);
      nl += int'(load === 1'b1);
    end
    check("pin loads", nl, 4);
    pend <= 1'b1;
    n = 0;
    while (load !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    check("pending load", n > 10 && n < 35, 1'b1);
    pend <= 1'b0;
    // holdover from pin ignores the line counts
    apb(1'b1, ba(IDX_PRE), 8'h02);
    apb(1'b1, ba(IDX_POST), 8'h02);
    apb(1'b1, ba(IDX_MISC), 8'h20);
    window(0);
    n = 0;
    repeat (10 * LINE)
    begin
      @(posedge mclk);
      n += int'(hold === 1'b1);
    end
    check("pin hold idle", n, 0);
    pin <= 1'b1;
    tick(5);
    check("pin hold", hold, 1'b1);
    pin <= 1'b0;
    // internal holdover around the frame sync
    apb(1'b1, ba(IDX_MISC), 8'h00);
    tick(20 * LINE);
    @(negedge frame_s);
    tick(LINE * 3 / 2);
    check("post hold", hold, 1'b1);
    tick(LINE);
    check("post release", hold, 1'b0);
    tick(4 * LINE);
    check("pre idle", hold, 1'b0);
    tick(LINE);
    check("pre hold", hold, 1'b1);
    end_sim();
  end
endmodule
